// ---- common/mux_ctrl_map.svh ----
// offsets, field positions and reset values of the monitor control register
// assumes inclusion by bare name from the design file and the bench
`ifndef MUX_CTRL_MAP_SVH
`define MUX_CTRL_MAP_SVH
// register index 02h, byte address on apb is four times it
`define MCTL_IDX 8'h02
`define MCTL_ADDR 12'h008
// field positions
`define MCTL_CLK_BIT 7
`define MCTL_VPWR_HI 6
`define MCTL_VPWR_LO 5
`define MCTL_RSEL_HI 4
`define MCTL_RSEL_LO 3
`define MCTL_MON_HI 2
`define MCTL_MON_LO 0
// reset values of the writable fields
`define MCTL_VPWR_RST 2'h0
`define MCTL_RSEL_RST 2'h0
`define MCTL_MON_RST 3'h0
`endif

// ---- common/mux_ctrl_pkg.sv ----
// types shared by the monitor control register block
// assumes the map header defines the numbers
package mux_ctrl_pkg;
   // reference power modes
   typedef enum logic [1:0] {
      VPWR_OFF = 2'h0,
      VPWR_ON = 2'h1,
      VPWR_FOLLOW = 2'h2,
      VPWR_FOLLOW2 = 2'h3
   } ref_power_t;
   // reference selections
   typedef enum logic [1:0] {
      RSEL_EXT0 = 2'h0,
      RSEL_EXT1 = 2'h1,
      RSEL_INT = 2'h2,
      RSEL_INT_DRIVE0 = 2'h3
   } ref_select_t;
   // system monitor settings
   typedef enum logic [2:0] {
      MON_NORMAL = 3'h0,
      MON_OFFSET = 3'h1,
      MON_GAIN = 3'h2,
      MON_TEMP = 3'h3,
      MON_REF1_Q = 3'h4,
      MON_REF0_Q = 3'h5,
      MON_AVDD_Q = 3'h6,
      MON_DVDD_Q = 3'h7
   } monitor_t;
   // analogue routing bundle handed to the front end
   typedef struct packed {
      logic ref_powered;
      logic [1:0] ref_source;
      logic ref_drive_ext0;
      logic inputs_released;
      logic [2:0] adc_input_source;
      logic bias_released;
      logic gain_forced_unity;
      logic [2:0] effective_gain;
   } analog_route_t;
endpackage

// ---- design/mux_ctrl_reg.sv ----
// apb register block for input, reference and monitor control, with analogue routing
// assumes a single pclk domain; clock source, start pin and sleep come from outside
`timescale 1ns/1ps
`include "mux_ctrl_map.svh"

module mux_ctrl_reg (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_clock_in_use,
   input wire logic start_pin,
   input wire logic sleep_cmd,
   input wire logic conversion_busy,
   input wire logic [2:0] stored_gain,
   output mux_ctrl_pkg::analog_route_t route
);
   // synchronisers for pin-side inputs
   logic clk_src_s1_reg;
   logic clk_src_s2_reg;
   logic start_s1_reg;
   logic start_s2_reg;
   // writable fields
   logic [1:0] vpwr_reg;
   logic [1:0] rsel_reg;
   logic [2:0] mon_reg;
   // reference awake latch for follow mode
   logic ref_awake_reg;
   logic ref_awake_next;
   // routing output register
   mux_ctrl_pkg::analog_route_t route_next;

   // decode
   wire apb_access = psel && penable && clk_en;
   wire hit = (paddr == `MCTL_ADDR);
   wire wr_hit = apb_access && pwrite && hit && pstrb[0];
   wire [7:0] reg_view = {clk_src_s2_reg, vpwr_reg, rsel_reg, mon_reg};
   wire monitor_active = (mon_reg != mux_ctrl_pkg::MON_NORMAL);
   wire gain_forced = (mon_reg != mux_ctrl_pkg::MON_NORMAL) &&
                      (mon_reg != mux_ctrl_pkg::MON_OFFSET);

   // two-flop synchronisers on the pin inputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_src_s1_reg <= 1'b0;
         clk_src_s2_reg <= 1'b0;
         start_s1_reg <= 1'b0;
         start_s2_reg <= 1'b0;
      end else if (clk_en) begin
         clk_src_s1_reg <= ext_clock_in_use;
         clk_src_s2_reg <= clk_src_s1_reg;
         start_s1_reg <= start_pin;
         start_s2_reg <= start_s1_reg;
      end
   end

   // writable fields; bit 7 ignores writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vpwr_reg <= `MCTL_VPWR_RST;
         rsel_reg <= `MCTL_RSEL_RST;
         mon_reg <= `MCTL_MON_RST;
      end else if (wr_hit) begin
         vpwr_reg <= pwdata[`MCTL_VPWR_HI:`MCTL_VPWR_LO];
         rsel_reg <= pwdata[`MCTL_RSEL_HI:`MCTL_RSEL_LO];
         mon_reg <= pwdata[`MCTL_MON_HI:`MCTL_MON_LO];
      end
   end

   // follow mode: wake on conversion, sleep on command or start low
   always_comb begin
      ref_awake_next = ref_awake_reg;
      if (sleep_cmd || !start_s2_reg) begin
         ref_awake_next = 1'b0;
      end else if (conversion_busy) begin
         ref_awake_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_awake_reg <= 1'b0;
      end else if (clk_en) begin
         ref_awake_reg <= ref_awake_next;
      end
   end

   // routing decode
   always_comb begin
      route_next = '0;
      case (vpwr_reg)
         mux_ctrl_pkg::VPWR_OFF: route_next.ref_powered = 1'b0;
         mux_ctrl_pkg::VPWR_ON: route_next.ref_powered = 1'b1;
         default: route_next.ref_powered = ref_awake_next;
      endcase
      route_next.ref_source = rsel_reg;
      route_next.ref_drive_ext0 = (rsel_reg == mux_ctrl_pkg::RSEL_INT_DRIVE0);
      route_next.inputs_released = monitor_active;
      route_next.bias_released = monitor_active;
      route_next.adc_input_source = mon_reg;
      route_next.gain_forced_unity = gain_forced;
      route_next.effective_gain = gain_forced ? 3'h0 : stored_gain;
   end

   // registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route <= '0;
      end else if (clk_en) begin
         route <= route_next;
      end
   end

   // apb answer: zero wait, unmapped reads zero with error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (paddr != `MCTL_ADDR);
         if (psel && !penable && !pwrite && hit) begin
            prdata <= {24'h00_0000, reg_view};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // assertions
   property p_ro_status;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit && clk_en) |=> prdata[7] == $past(clk_src_s2_reg);
   endproperty
   a_ro_status: assert property (p_ro_status) else $error("status bit wrong");
   property p_pwr_off;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && vpwr_reg == 2'h0) |=> !route.ref_powered;
   endproperty
   a_pwr_off: assert property (p_pwr_off) else $error("reference not off");
   property p_pwr_sleep;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && vpwr_reg[1] && sleep_cmd) |=> !route.ref_powered;
   endproperty
   a_pwr_sleep: assert property (p_pwr_sleep) else $error("reference on after sleep");
   property p_drive_ext0;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && rsel_reg == 2'h3) |=> route.ref_drive_ext0 && route.ref_source == 2'h3;
   endproperty
   a_drive_ext0: assert property (p_drive_ext0) else $error("ext0 drive missing");
   property p_override;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && mon_reg != 3'h0) |=> route.inputs_released && route.bias_released;
   endproperty
   a_override: assert property (p_override) else $error("monitor not overriding");
   property p_gain_unity;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && mon_reg[2:1] != 2'h0) |=> route.effective_gain == 3'h0;
   endproperty
   a_gain_unity: assert property (p_gain_unity) else $error("gain not unity");
   property p_gain_restore;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && mon_reg[2:1] == 2'h0) |=> route.effective_gain == $past(stored_gain);
   endproperty
   a_gain_restore: assert property (p_gain_restore) else $error("gain not restored");
   property p_write_takes;
      @(posedge pclk) disable iff (!presetn)
      wr_hit |=> mon_reg == $past(pwdata[2:0]) && vpwr_reg == $past(pwdata[6:5]);
   endproperty
   a_write_takes: assert property (p_write_takes) else $error("write lost");
   property p_mon_code;
      @(posedge pclk) disable iff (!presetn)
      clk_en |=> route.adc_input_source == $past(mon_reg);
   endproperty
   a_mon_code: assert property (p_mon_code) else $error("monitor code wrong");

   // reference power, fixed on and follow mode wake and start-low
   property p_pwr_on;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && vpwr_reg == 2'h1) |=> route.ref_powered;
   endproperty
   a_pwr_on: assert property (p_pwr_on) else $error("reference not on");

   property p_pwr_start;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && vpwr_reg[1] && !start_s2_reg) |=> !route.ref_powered;
   endproperty
   a_pwr_start: assert property (p_pwr_start) else $error("reference on, start low");

   property p_pwr_wake;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && vpwr_reg[1] && conversion_busy && !sleep_cmd && start_s2_reg)
         |=> route.ref_powered;
   endproperty
   a_pwr_wake: assert property (p_pwr_wake) else $error("reference not woken");

   // reference selection and the drive onto the first pair
   property p_ref_source;
      @(posedge pclk) disable iff (!presetn)
      clk_en |=> route.ref_source == $past(rsel_reg);
   endproperty
   a_ref_source: assert property (p_ref_source) else $error("reference source wrong");

   property p_no_drive;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && rsel_reg != 2'h3) |=> !route.ref_drive_ext0;
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("stray ext0 drive");

   property p_drive_pair;
      @(posedge pclk) disable iff (!presetn)
      route.ref_drive_ext0 |-> route.ref_source == 2'h3;
   endproperty
   a_drive_pair: assert property (p_drive_pair) else $error("drive source wrong");

   // monitor override and forced gain flag
   property p_normal_inputs;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && mon_reg == 3'h0) |=> !route.inputs_released && !route.bias_released;
   endproperty
   a_normal_inputs: assert property (p_normal_inputs) else $error("inputs released");

   property p_unity_flag;
      @(posedge pclk) disable iff (!presetn)
      clk_en |=> route.gain_forced_unity == ($past(mon_reg) >= 3'h2);
   endproperty
   a_unity_flag: assert property (p_unity_flag) else $error("unity flag wrong");

   // apb answer timing and refused writes
   property p_ready_pulse;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && psel && !penable) |=> pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("no ready in access");

   property p_ready_drop;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && psel && penable) |=> !pready;
   endproperty
   a_ready_drop: assert property (p_ready_drop) else $error("ready held");

   property p_bad_addr;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && psel && !penable && !hit) |=> pslverr;
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("no address error");

   property p_bad_write;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && psel && penable && pwrite && !hit)
         |=> $stable(vpwr_reg) && $stable(rsel_reg) && $stable(mon_reg);
   endproperty
   a_bad_write: assert property (p_bad_write) else $error("stray write taken");

   property p_masked_write;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && psel && penable && pwrite && !pstrb[0])
         |=> $stable(vpwr_reg) && $stable(rsel_reg) && $stable(mon_reg);
   endproperty
   a_masked_write: assert property (p_masked_write) else $error("masked write taken");

   // covers of the main scenarios
   c_write: cover property (@(posedge pclk) wr_hit);
   c_follow: cover property (@(posedge pclk) vpwr_reg[1] && route.ref_powered);
   c_monitor: cover property (@(posedge pclk) route.gain_forced_unity);
   c_sleep: cover property (@(posedge pclk) vpwr_reg[1] && sleep_cmd && conversion_busy);
   c_restore: cover property (@(posedge pclk) mon_reg == 3'h0 && $past(mon_reg) == 3'h7);
endmodule

// ---- test/tb.sv ----
// self-checking bench for the monitor control register block
// assumes the map header and the package are compiled first
`timescale 1ns/1ps
`include "mux_ctrl_map.svh"
module tb;
   logic pclk = 1'h0; // 4 ns clock
   logic presetn = 1'h0; // reset, active low
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0; // apb control
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [3:0] pstrb = 4'h0;
   logic pready, pslverr, err;
   logic ext = 1'h0, start = 1'h1, sleep = 1'h0, busy = 1'h0; // device side inputs
   logic en = 1'h1; // clock enable
   logic [2:0] gain = 3'h5; // stored gain field of the gain and rate register
   mux_ctrl_pkg::analog_route_t route; // analogue routing seen
   int err_total = 0, num_checks = 0, cyc = 0;
   always #2 pclk = ~pclk;
   mux_ctrl_reg dut (.pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clock_in_use(ext),
      .start_pin(start), .sleep_cmd(sleep), .conversion_busy(busy),
      .stored_gain(gain), .route(route));
   // compare and count
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task tick(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // one apb transfer, held until pready is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= a;
      pwdata <= {24'h00_0000, d}; pstrb <= s;
      @(posedge pclk);
      penable <= 1'h1;
      // wait for the answer; only the bench timeout ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata; err = pslverr;
      psel <= 1'h0; penable <= 1'h0;
   endtask
   // values straight after reset
   task t_reset;
      apb(1'h0, `MCTL_ADDR, 8'h00, 4'hf);
      chk("reset value", 32'h0000_0000, rd);
      chk("gain after reset", 32'h0000_0005, 32'(route.effective_gain));
      chk("ref power reset", 32'h0000_0000, 32'(route.ref_powered));
   endtask
   // clock flag follows the input, ignores writes
   task t_clock;
      ext <= 1'h1; tick(4);
      apb(1'h1, `MCTL_ADDR, 8'h00, 4'hf);
      apb(1'h0, `MCTL_ADDR, 8'h00, 4'hf);
      chk("clock flag", 32'h0000_0080, rd);
      ext <= 1'h0; tick(4);
   endtask
   // every monitor code, each paired with reference select code m modulo 4
   task t_fields;
      logic [7:0] v;
      for (int m = 0; m < 8; m++) begin
         v = {1'h0, 2'h1, 2'(m), 3'(m)};
         apb(1'h1, `MCTL_ADDR, v, 4'hf);
         apb(1'h0, `MCTL_ADDR, 8'h00, 4'hf);
         chk("readback", {24'h00_0000, v}, rd);
         tick(3);
         chk("monitor source", 32'(m), 32'(route.adc_input_source));
         chk("bias override", 32'(m != 0), 32'(route.bias_released));
         chk("input override", 32'(m != 0), 32'(route.inputs_released));
         chk("unity forced", 32'(m >= 2), 32'(route.gain_forced_unity));
         chk("gain", (m >= 2) ? 32'h0 : 32'h5, 32'(route.effective_gain));
         chk("ref source", 32'(m % 4), 32'(route.ref_source));
         chk("ref drive", 32'(m % 4 == 3), 32'(route.ref_drive_ext0));
         chk("ref on", 32'h1, 32'(route.ref_powered));
      end
   endtask
   // reference power modes, off, follow with sleep and start low
   task t_power;
      apb(1'h1, `MCTL_ADDR, 8'h00, 4'hf); tick(3);
      chk("ref off", 32'h0, 32'(route.ref_powered));
      chk("gain restored", 32'h5, 32'(route.effective_gain));
      gain <= 3'h2; tick(2);
      chk("gain follows stored", 32'h2, 32'(route.effective_gain));
      for (int p = 2; p < 4; p++) begin
         apb(1'h1, `MCTL_ADDR, {1'h0, 2'(p), 5'h00}, 4'hf);
         busy <= 1'h1; tick(3);
         chk("ref converting", 32'h1, 32'(route.ref_powered));
         start <= 1'h0; tick(6);
         chk("ref start low", 32'h0, 32'(route.ref_powered));
         start <= 1'h1; sleep <= 1'h1; tick(6);
         chk("ref sleep", 32'h0, 32'(route.ref_powered));
         sleep <= 1'h0; busy <= 1'h0;
      end
   endtask
   // clock enable low freezes the routing outputs
   task t_freeze;
      en <= 1'h0; gain <= 3'h6; tick(4);
      chk("frozen gain", 32'h2, 32'(route.effective_gain));
      en <= 1'h1; tick(3);
      chk("gain after freeze", 32'h6, 32'(route.effective_gain));
   endtask
   // unmapped address, masked lane, read-only bit
   task t_refuse;
      apb(1'h1, 12'h00c, 8'h7f, 4'hf);
      chk("bad address error", 32'h1, 32'(err));
      apb(1'h1, `MCTL_ADDR, 8'hff, 4'h0);
      apb(1'h0, `MCTL_ADDR, 8'h00, 4'hf);
      chk("unchanged", 32'h0000_0060, rd);
      chk("good address", 32'h0, 32'(err));
      apb(1'h1, `MCTL_ADDR, 8'h80, 4'hf);
      apb(1'h0, `MCTL_ADDR, 8'h00, 4'hf);
      chk("flag not written", 32'h0000_0000, rd);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // cut a hang short
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         wrap_up;
      end
   end
   initial begin
      tick(6);
      presetn <= 1'h1;
      t_reset;
      t_clock;
      t_fields;
      t_power;
      t_freeze;
      t_refuse;
      wrap_up;
   end
endmodule
